// file: rtl/pcp_char_fifo.sv
// Purpose: Character queue between the host line and the command parser.
// Assumes: Single clock; both sides use valid and ready.
// Notes: The ready on the filling side is a flop, so a full queue stalls the host.
`timescale 1ns/100ps
module pcp_char_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = pcp_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  import pcp_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic full_q;
  logic push;
  logic pop;

  assign push = in_valid && !full_q;
  assign pop = out_ready && (cnt_q != '0);
  assign in_ready = !full_q;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      full_q <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      full_q <= (cnt_d == (AW + 1)'(DEPTH));
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

endmodule : pcp_char_fifo

// file: rtl/pcp_parser.sv
// Purpose: Character command interpreter for a serial matrix printer without line buffer option.
// Assumes: The mechanism raises mech_busy the cycle after a command and holds it until done.
// Notes: Options and the strap are steady levels synchronous to mclk.
`timescale 1ns/100ps
module pcp_parser #(
  parameter int FIFO_DEPTH = pcp_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Host character stream.
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // Installed options and strap.
  input wire logic no_delete_option,
  input wire logic select_disable_strap,
  input wire logic vertical_format_memory,
  input wire logic expanded_print_option,
  // Print mechanism.
  input wire logic mech_busy,
  output pcp_pkg::pcp_mech_cmd_type mech_cmd,
  output pcp_pkg::pcp_lb_wr_type lb_wr,
  // Status.
  output pcp_pkg::pcp_status_type status
);
  import pcp_pkg::*;

  // Smallest set horizontal tab beyond the column, or zero when none.
  function automatic logic [7:0] next_htab(input logic [HTAB_BITS-1:0] tabs,
                                           input logic [7:0] col);
    logic [7:0] r;
    r = 8'h00;
    for (int i = HTAB_BITS - 1; i >= 0; i--) begin
      if (tabs[i] && (8'(i) > col)) begin
        r = 8'(i);
      end
    end
    return r;
  endfunction : next_htab

  // Smallest set vertical tab beyond the line within the form, else the form length.
  function automatic logic [6:0] next_vtab(input logic [VTAB_BITS-1:0] tabs,
                                           input logic [6:0] line,
                                           input logic [6:0] flen);
    logic [6:0] r;
    r = flen;
    for (int i = VTAB_BITS - 1; i >= 0; i--) begin
      if (tabs[i] && (7'(i) > line) && (7'(i) < flen)) begin
        r = 7'(i);
      end
    end
    return r;
  endfunction : next_vtab

  logic q_valid;
  logic [7:0] q_data;
  logic pop;
  logic [7:0] ch;
  logic [6:0] n;

  pcp_state_type st_q, st_d;
  logic [7:0] col_q, col_d;
  logic [7:0] fill_to_q, fill_to_d;
  logic [7:0] car_q, car_d;
  logic [6:0] line_q, line_d;
  logic [6:0] form_len_q, form_len_d;
  logic [6:0] form_next_q, form_next_d;
  logic [7:0] width_q, width_d;
  logic [HTAB_BITS-1:0] htabs_q, htabs_d;
  logic [VTAB_BITS-1:0] vtabs_q, vtabs_d;
  logic sel_q, sel_d;
  logic lpi8_q, lpi8_d;
  logic cpi16_q, cpi16_d;
  logic exp_q, exp_d;
  pcp_mech_cmd_type cmd_q, cmd_d;
  pcp_lb_wr_type lb_q, lb_d;
  pcp_vfmt_type vfm_q [VFM_CHANNELS];
  logic vfm_we;
  logic [2:0] vfm_idx;

  logic term;
  logic paper;
  logic [6:0] feed_n;
  logic put_ch;
  logic [7:0] plen;
  logic [7:0] dist_rev;

  pcp_char_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data(rx_data),
    .out_valid(q_valid),
    .out_ready(pop),
    .out_data(q_data)
  );

  assign ch = {1'b0, q_data[6:0]};
  assign n = q_data[6:0];
  assign mech_cmd = cmd_q;
  assign lb_wr = lb_q;
  assign status = '{selected: sel_q || select_disable_strap, lpi8: lpi8_q, cpi16: cpi16_q,
                    expanded: exp_q, width: width_q, line: line_q, form_len: form_len_q};

  always_comb begin
    st_d = st_q;
    col_d = col_q;
    fill_to_d = fill_to_q;
    car_d = car_q;
    line_d = line_q;
    form_len_d = form_len_q;
    form_next_d = form_next_q;
    width_d = width_q;
    htabs_d = htabs_q;
    vtabs_d = vtabs_q;
    sel_d = sel_q;
    lpi8_d = lpi8_q;
    cpi16_d = cpi16_q;
    exp_d = exp_q;
    cmd_d = '0;
    lb_d = '0;
    vfm_we = 1'b0;
    vfm_idx = 3'(ch - CHAN_FIRST);
    pop = 1'b0;
    term = 1'b0;
    paper = 1'b0;
    feed_n = 7'h00;
    put_ch = 1'b0;
    plen = (col_q > width_q) ? width_q : col_q;
    dist_rev = (car_q > plen) ? car_q - plen : plen - car_q;
    // Nothing moves while the mechanism works or a command is still being taken up.
    if (!mech_busy && !cmd_q.print && !cmd_q.feed) begin
      if (st_q == PCP_FILL) begin
        if (col_q < fill_to_q) begin
          lb_d = '{wr: 1'b1, clr: 1'b0, col: col_q, data: CH_SPACE};
          col_d = col_q + 8'h01;
        end else begin
          st_d = PCP_IDLE;
        end
      end else if (q_valid) begin
        pop = 1'b1;
        case (st_q)
          PCP_IDLE: begin
            if (!sel_q && !select_disable_strap && ch != CH_DC1) begin
              // Deselected: the character is dropped.
              st_d = PCP_IDLE;
            end else if (ch == CH_CR) begin
              term = 1'b1;
            end else if (ch == CH_LF) begin
              term = 1'b1;
              paper = 1'b1;
              feed_n = 7'h01;
            end else if (ch == CH_FF) begin
              term = 1'b1;
              paper = 1'b1;
              feed_n = form_len_q - line_q;
              form_len_d = form_next_q;
            end else if (ch == CH_VT) begin
              term = 1'b1;
              paper = 1'b1;
              feed_n = next_vtab(vtabs_q, line_q, form_len_q) - line_q;
            end else if (ch == CH_DC2) begin
              st_d = PCP_TLINE;
            end else if (ch == CH_DC4) begin
              st_d = PCP_TADDR;
            end else if (ch == CH_ESC) begin
              st_d = PCP_ESC;
            end else if (ch == CH_DC3) begin
              if (!select_disable_strap) begin
                term = 1'b1;
                sel_d = 1'b0;
              end
            end else if (ch == CH_DC1) begin
              if (!select_disable_strap) begin
                sel_d = 1'b1;
              end
            end else if (ch == CH_HT) begin
              if (next_htab(htabs_q, col_q) > col_q) begin
                fill_to_d = next_htab(htabs_q, col_q);
                st_d = PCP_FILL;
              end
            end else if (ch == CH_DEL) begin
              if (!no_delete_option) begin
                lb_d.clr = 1'b1;
                col_d = 8'h00;
                exp_d = 1'b0;
              end
            end else if (ch == CH_SO) begin
              if (expanded_print_option && col_q == 8'h00) begin
                exp_d = 1'b1;
              end
            end else if (ch >= CH_SPACE && ch <= CH_TILDE) begin
              put_ch = 1'b1;
              term = (col_q == COL_FULL);
            end
          end
          PCP_ESC: begin
            st_d = PCP_IDLE;
            if (ch == ESC_HTAB_SET) begin
              htabs_d = '0;
              st_d = PCP_HSET;
            end else if (ch == ESC_VTAB_SET) begin
              vtabs_d = '0;
              st_d = PCP_VSET;
            end else if (ch == ESC_FORM_LEN) begin
              st_d = PCP_FLEN;
            end else if (ch == ESC_WIDTH) begin
              st_d = PCP_WIDTH;
            end else if (ch == ESC_WIDTH_FULL) begin
              width_d = COL_FULL;
            end else if (ch == ESC_LPI6) begin
              lpi8_d = 1'b0;
            end else if (ch == ESC_LPI8) begin
              lpi8_d = 1'b1;
            end else if (ch == ESC_CPI10) begin
              cpi16_d = 1'b0;
            end else if (ch == ESC_CPI16) begin
              cpi16_d = 1'b1;
            end else if (ch == ESC_STORE) begin
              st_d = PCP_STORE;
            end else if (ch == ESC_RECALL) begin
              st_d = PCP_RECALL;
            end
          end
          PCP_HSET: begin
            if (ch == CH_NUL) begin
              st_d = PCP_IDLE;
            end else if ({1'b0, n} <= COL_TAB_MAX) begin
              htabs_d[n] = 1'b1;
            end
          end
          PCP_VSET: begin
            if (ch == CH_NUL) begin
              st_d = PCP_IDLE;
            end else if (n <= LINE_TAB_MAX) begin
              vtabs_d[n] = 1'b1;
            end
          end
          PCP_FLEN: begin
            st_d = PCP_IDLE;
            if (n >= FORM_LEN_MIN && n <= FORM_LEN_MAX) begin
              form_len_d = n;
              form_next_d = n;
              if (line_q >= n) begin
                line_d = 7'h00;
              end
            end
          end
          PCP_WIDTH: begin
            st_d = PCP_IDLE;
            if (n >= WIDTH_MIN && n <= WIDTH_MAX) begin
              width_d = {1'b0, n};
            end
          end
          PCP_STORE, PCP_RECALL: begin
            st_d = PCP_IDLE;
            if (vertical_format_memory && ch >= CHAN_FIRST && ch <= CHAN_LAST) begin
              if (st_q == PCP_STORE) begin
                vfm_we = 1'b1;
              end else begin
                lpi8_d = vfm_q[vfm_idx].lpi8;
                vtabs_d = vfm_q[vfm_idx].vtabs;
                form_next_d = vfm_q[vfm_idx].form_len;
              end
            end
          end
          PCP_TADDR: begin
            st_d = PCP_IDLE;
            fill_to_d = ({1'b0, n} > COL_TAB_MAX) ? COL_TAB_MAX : {1'b0, n};
            if (fill_to_d >= col_q) begin
              st_d = PCP_FILL;
            end
          end
          PCP_TLINE: begin
            st_d = PCP_IDLE;
            if (n >= line_q && n < form_len_q) begin
              term = 1'b1;
              paper = 1'b1;
              feed_n = n - line_q;
            end
          end
          default: begin
            st_d = PCP_IDLE;
          end
        endcase
      end
    end
    // Line end: print what is buffered, move paper when asked, restart at the left margin.
    if (term) begin
      cmd_d.print = (col_q != 8'h00);
      cmd_d.len = plen;
      cmd_d.reverse = (dist_rev < car_q);
      if (col_q != 8'h00) begin
        car_d = (dist_rev < car_q) ? 8'h00 : plen;
      end
      cmd_d.feed = paper;
      cmd_d.lines = feed_n;
      lb_d.clr = 1'b1;
      col_d = 8'h00;
      exp_d = 1'b0;
      if (paper) begin
        line_d = (line_q + feed_n >= form_len_q) ? 7'h00 : line_q + feed_n;
      end
    end
    if (put_ch) begin
      lb_d.wr = 1'b1;
      lb_d.col = term ? 8'h00 : col_q;
      lb_d.data = ch;
      col_d = term ? 8'h01 : col_q + 8'h01;
    end
  end

  // Parser state and line position.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= PCP_IDLE;
      col_q <= 8'h00;
      fill_to_q <= 8'h00;
      car_q <= 8'h00;
      line_q <= 7'h00;
    end else begin
      st_q <= st_d;
      col_q <= col_d;
      fill_to_q <= fill_to_d;
      car_q <= car_d;
      line_q <= line_d;
    end
  end

  // Working format and print modes.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      form_len_q <= FORM_LEN_RESET;
      form_next_q <= FORM_LEN_RESET;
      width_q <= WIDTH_RESET;
      htabs_q <= '0;
      vtabs_q <= '0;
      sel_q <= 1'b0;
      lpi8_q <= 1'b0;
      cpi16_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      form_len_q <= form_len_d;
      form_next_q <= form_next_d;
      width_q <= width_d;
      htabs_q <= htabs_d;
      vtabs_q <= vtabs_d;
      sel_q <= sel_d;
      lpi8_q <= lpi8_d;
      cpi16_q <= cpi16_d;
      exp_q <= exp_d;
    end
  end

  // Mechanism and line buffer requests, one cycle each.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= '0;
      lb_q <= '0;
    end else begin
      cmd_q <= cmd_d;
      lb_q <= lb_d;
    end
  end

  // Stored vertical formats.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < VFM_CHANNELS; i++) begin
        vfm_q[i] <= '{lpi8: 1'b0, form_len: FORM_LEN_RESET, vtabs: '0};
      end
    end else if (vfm_we) begin
      vfm_q[vfm_idx] <= '{lpi8: lpi8_q, form_len: form_len_q, vtabs: vtabs_q};
    end
  end

endmodule : pcp_parser

// file: rtl/pcp_pkg.sv
// Purpose: Shared constants and carrier types for the printer character command parser.
// Assumes: Seven-bit ASCII characters; bit 7 of a received byte is ignored.
// Notes: Column and line numbers count from zero.
package pcp_pkg;

  // Control characters.
  localparam logic [7:0] CH_NUL = 8'h00;
  localparam logic [7:0] CH_HT = 8'h09;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_VT = 8'h0B;
  localparam logic [7:0] CH_FF = 8'h0C;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_SO = 8'h0E;
  localparam logic [7:0] CH_DC1 = 8'h11;
  localparam logic [7:0] CH_DC2 = 8'h12;
  localparam logic [7:0] CH_DC3 = 8'h13;
  localparam logic [7:0] CH_DC4 = 8'h14;
  localparam logic [7:0] CH_ESC = 8'h1B;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_TILDE = 8'h7E;
  localparam logic [7:0] CH_DEL = 8'h7F;

  // Second character of escape sequences, and the channel characters that follow store and recall.
  localparam logic [7:0] ESC_HTAB_SET = 8'h31;
  localparam logic [7:0] ESC_FORM_LEN = 8'h32;
  localparam logic [7:0] ESC_VTAB_SET = 8'h33;
  localparam logic [7:0] ESC_LPI6 = 8'h34;
  localparam logic [7:0] ESC_LPI8 = 8'h35;
  localparam logic [7:0] ESC_CPI10 = 8'h36;
  localparam logic [7:0] ESC_CPI16 = 8'h37;
  localparam logic [7:0] ESC_STORE = 8'h38;
  localparam logic [7:0] ESC_RECALL = 8'h39;
  localparam logic [7:0] ESC_WIDTH = 8'h3A;
  localparam logic [7:0] ESC_WIDTH_FULL = 8'h3B;
  localparam logic [7:0] CHAN_FIRST = 8'h31;
  localparam logic [7:0] CHAN_LAST = 8'h38;

  // Limits and counts.
  localparam logic [7:0] COL_FULL = 8'd132;
  localparam logic [7:0] COL_TAB_MAX = 8'd126;
  localparam logic [6:0] LINE_TAB_MAX = 7'd112;
  localparam logic [6:0] FORM_LEN_MIN = 7'd4;
  localparam logic [6:0] FORM_LEN_MAX = 7'd112;
  localparam logic [6:0] WIDTH_MIN = 7'd2;
  localparam logic [6:0] WIDTH_MAX = 7'd126;
  localparam int HTAB_BITS = 127;
  localparam int VTAB_BITS = 113;
  localparam int VFM_CHANNELS = 8;
  localparam int FIFO_DEPTH = 16;

  // Values after reset.
  localparam logic [7:0] WIDTH_RESET = 8'd132;
  localparam logic [6:0] FORM_LEN_RESET = 7'd66;

  typedef enum logic [3:0] {
    PCP_IDLE, PCP_ESC, PCP_HSET, PCP_VSET, PCP_FLEN, PCP_WIDTH,
    PCP_STORE, PCP_RECALL, PCP_TADDR, PCP_TLINE, PCP_FILL
  } pcp_state_type;

  // One write into the external line buffer.
  typedef struct packed {
    logic wr;
    logic clr;
    logic [7:0] col;
    logic [7:0] data;
  } pcp_lb_wr_type;

  // One request to the print and paper mechanism: print first, then feed.
  typedef struct packed {
    logic print;
    logic reverse;
    logic [7:0] len;
    logic feed;
    logic [6:0] lines;
  } pcp_mech_cmd_type;

  // A stored vertical format.
  typedef struct packed {
    logic lpi8;
    logic [6:0] form_len;
    logic [VTAB_BITS-1:0] vtabs;
  } pcp_vfmt_type;

  // Visible printer state.
  typedef struct packed {
    logic selected;
    logic lpi8;
    logic cpi16;
    logic expanded;
    logic [7:0] width;
    logic [6:0] line;
    logic [6:0] form_len;
  } pcp_status_type;

endpackage : pcp_pkg

// file: test/pcp_host_model.sv
// Purpose: Host model that offers queued characters to the parser.
// Assumes: One character is offered at a time and held until taken.
// Notes: The data line changes every cycle while nothing is offered.
`timescale 1ns/100ps
module pcp_host_model (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Character line.
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready
);
  logic [7:0] pend[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h55;
  end
  // Each parameter goes out as one character holding its binary value.
  always @(posedge mclk) begin
    if (rx_valid && rx_ready) void'(pend.pop_front());
    #1;
    rx_valid = rst_n && pend.size() > 0;
    rx_data = rx_valid ? pend[0] : ~rx_data;
  end
  task automatic send(input logic [7:0] c);
    pend.push_back(c);
  endtask : send
endmodule : pcp_host_model

// file: test/pcp_parser_monitor.sv
// Purpose: Concurrent checks on the parser ports.
// Assumes: One clock domain.
// Notes: Bound from the bench top.
`timescale 1ns/100ps
module pcp_parser_monitor (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Watched signals.
  input wire logic select_disable_strap,
  input wire logic mech_busy,
  input wire pcp_pkg::pcp_mech_cmd_type mech_cmd,
  input wire pcp_pkg::pcp_lb_wr_type lb_wr,
  input wire pcp_pkg::pcp_status_type status
);
  import pcp_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_cmd_single: assert property (
    mech_cmd.print || mech_cmd.feed |=> !(mech_cmd.print || mech_cmd.feed))
    else $error("command pulse too long");
  a_write_idle: assert property (lb_wr.wr |-> !$past(mech_busy))
    else $error("write while mechanism busy");
  a_print_clears: assert property (mech_cmd.print |-> lb_wr.clr)
    else $error("print without buffer clear");
  a_len_width: assert property (mech_cmd.print |-> mech_cmd.len <= status.width)
    else $error("print length beyond width");
  a_width_legal: assert property (
    status.width inside {[8'h02:8'h7E], 8'h84})
    else $error("illegal width");
  a_flen_legal: assert property (status.form_len inside {[7'h04:7'h70]})
    else $error("illegal form length");
  a_desel_quiet: assert property (!status.selected [*2] |-> !lb_wr.wr)
    else $error("write while deselected");
  a_strap_sel: assert property (
    select_disable_strap && $past(select_disable_strap) |-> status.selected)
    else $error("deselected with strap fitted");
  c_feed: cover property (mech_cmd.feed);
  c_pad: cover property (lb_wr.wr && lb_wr.data == CH_SPACE);
  c_desel: cover property ($fell(status.selected));
endmodule : pcp_parser_monitor

// file: test/pcp_parser_tb_top.sv
// Purpose: Self-checking bench for the parser.
// Assumes: The mechanism stays busy three cycles per command.
// Notes: Inputs change 1 ns after the clock edge.
`timescale 1ns/100ps
`define CK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module pcp_parser_tb_top;
  import pcp_pkg::*;
  logic mclk = 0, rst_n = 0, mech_busy = 0, rx_valid, rx_ready, hold = 0;
  logic [7:0] rx_data;
  logic no_delete_option = 0, select_disable_strap = 0;
  logic vertical_format_memory = 0, expanded_print_option = 0;
  pcp_mech_cmd_type mech_cmd, lc;
  pcp_lb_wr_type lb_wr, lw;
  pcp_status_type status;
  int num_errors = 0, total_checks = 0, nw = 0, nc = 0, ncl = 0, bc = 0;
  always #2.5 mclk = ~mclk;
  pcp_host_model host_u (.mclk, .rst_n, .rx_valid, .rx_data, .rx_ready);
  pcp_parser dut_u (.mclk, .rst_n, .rx_valid, .rx_data, .rx_ready, .no_delete_option,
    .select_disable_strap, .vertical_format_memory, .expanded_print_option,
    .mech_busy, .mech_cmd, .lb_wr, .status);
  // Mechanism stand-in; it also records the last command and write.
  always @(posedge mclk) begin
    if (mech_cmd.print || mech_cmd.feed) begin
      lc = mech_cmd;
      nc++;
      bc = 3;
    end
    if (lb_wr.wr) begin
      lw = lb_wr;
      nw++;
    end
    if (lb_wr.clr) ncl++;
    // A held mechanism lets the queue fill up behind it.
    #1 mech_busy = (bc > 0) || hold;
    if (bc > 0) bc--;
  end
  task automatic dr();
    int q = 0;
    for (int i = 0; i < 3000 && q < 24; i++) begin
      @(posedge mclk);
      q = (host_u.pend.size() == 0 && !rx_valid && !mech_busy && !lb_wr.wr) ? q + 1 : 0;
    end
    #1;
  endtask : dr
  task automatic tx(input logic [7:0] a[$]);
    foreach (a[i]) host_u.send(a[i]);
    dr();
  endtask : tx
  task automatic t_sel();
    tx({8'h41});
    `CK("desel", 0, nw)
    tx({CH_DC1, 8'h41, 8'h42});
    `CK("sel", 1'b1, status.selected)
    `CK("col", 8'h01, lw.col)
    `CK("data", 8'h42, lw.data)
    tx({CH_LF});
    `CK("len", 8'h02, lc.len)
    `CK("lf", 8'h81, {lc.feed, lc.lines})
    tx({8'h43});
    `CK("margin", 8'h00, lw.col)
    $display("t_sel done");
  endtask : t_sel
  task automatic t_del();
    int c = ncl;
    tx({CH_DEL, 8'h44});
    `CK("clr", c + 1, ncl)
    `CK("del", 8'h00, lw.col)
    no_delete_option = 1'b1;
    tx({CH_DEL, 8'h45});
    `CK("nodel", 8'h01, lw.col)
    no_delete_option = 1'b0;
    $display("t_del done");
  endtask : t_del
  task automatic t_fmt();
    tx({CH_ESC, ESC_FORM_LEN, 8'h0A, CH_ESC, ESC_WIDTH, 8'h28, CH_FF});
    `CK("flen", 7'h0A, status.form_len)
    `CK("width", 8'h28, status.width)
    `CK("ff", 8'h89, {lc.feed, lc.lines})
    `CK("top", 7'h00, status.line)
    tx({CH_ESC, ESC_WIDTH, 8'h01, CH_ESC, ESC_LPI8, CH_ESC, ESC_CPI16});
    `CK("wkeep", 8'h28, status.width)
    `CK("pitch", 2'b11, {status.lpi8, status.cpi16})
    tx({CH_ESC, ESC_WIDTH_FULL, CH_ESC, ESC_LPI6, CH_ESC, ESC_CPI10});
    `CK("wfull", 8'h84, status.width)
    `CK("pitch0", 2'b00, {status.lpi8, status.cpi16})
    $display("t_fmt done");
  endtask : t_fmt
  task automatic t_tab();
    int w = nw;
    tx({CH_ESC, ESC_HTAB_SET, 8'h05, 8'h0A, CH_NUL, CH_HT, 8'h41});
    `CK("htn", w + 6, nw)
    `CK("htc", 8'h05, lw.col)
    tx({CH_DC4, 8'h08, 8'h42, CH_DC4, 8'h03, 8'h43});
    `CK("dc4c", 8'h09, lw.col)
    `CK("dc4n", w + 10, nw)
    tx({CH_CR});
    `CK("cr", 10'h00A, {lc.reverse, lc.feed, lc.len})
    tx({8'h41, CH_CR});
    `CK("rev", 1'b1, lc.reverse)
    $display("t_tab done");
  endtask : t_tab
  task automatic t_vt();
    int c;
    tx({CH_ESC, ESC_VTAB_SET, 8'h03, CH_NUL, CH_VT});
    `CK("vtab", 7'h03, status.line)
    tx({CH_DC2, 8'h07});
    `CK("dc2", 7'h04, lc.lines)
    c = nc;
    tx({CH_DC2, 8'h05});
    `CK("dc2lo", c, nc)
    tx({CH_VT});
    `CK("vtop", 7'h03, lc.lines)
    `CK("vline", 7'h00, status.line)
    $display("t_vt done");
  endtask : t_vt
  task automatic t_ovf();
    int c = nc;
    repeat (133) host_u.send(8'h41);
    dr();
    `CK("ovfn", c + 1, nc)
    `CK("ovfl", 8'h84, lc.len)
    `CK("ovfc", 8'h00, lw.col)
    tx({CH_CR});
    $display("t_ovf done");
  endtask : t_ovf
  task automatic t_dsel();
    int w;
    tx({8'h41, CH_DC3});
    `CK("dprint", 9'h001, {lc.feed, lc.len})
    `CK("off", 1'b0, status.selected)
    w = nw;
    tx({8'h42});
    `CK("drop", w, nw)
    select_disable_strap = 1'b1;
    tx({CH_DC1, CH_DC3});
    `CK("strap", 1'b1, status.selected)
    select_disable_strap = 1'b0;
    tx({CH_DC1});
    $display("t_dsel done");
  endtask : t_dsel
  task automatic t_vfm();
    vertical_format_memory = 1'b1;
    tx({CH_ESC, ESC_LPI8, CH_ESC, ESC_STORE, CHAN_FIRST});
    tx({CH_ESC, ESC_LPI6, CH_ESC, ESC_RECALL, CHAN_FIRST});
    `CK("recall", 1'b1, status.lpi8)
    vertical_format_memory = 1'b0;
    tx({CH_ESC, ESC_LPI6, CH_ESC, ESC_RECALL, CHAN_FIRST});
    `CK("novfm", 1'b0, status.lpi8)
    $display("t_vfm done");
  endtask : t_vfm
  task automatic t_exp();
    expanded_print_option = 1'b1;
    tx({8'h41, CH_SO});
    `CK("notfirst", 1'b0, status.expanded)
    tx({CH_CR, CH_NUL, CH_SO});
    `CK("exp", 1'b1, status.expanded)
    tx({CH_CR});
    `CK("expend", 1'b0, status.expanded)
    expanded_print_option = 1'b0;
    tx({CH_SO});
    `CK("noexp", 1'b0, status.expanded)
    $display("t_exp done");
  endtask : t_exp
  task automatic t_full();
    int w = nw;
    hold = 1'b1;
    @(posedge mclk);
    #1;
    repeat (20) host_u.send(8'h46);
    repeat (30) @(posedge mclk);
    #1;
    `CK("full", 1'b0, rx_ready)
    `CK("held", 4, host_u.pend.size())
    `CK("stall", w, nw)
    hold = 1'b0;
    dr();
    `CK("drain", w + 20, nw)
    `CK("ready", 1'b1, rx_ready)
    tx({CH_CR});
    $display("t_full done");
  endtask : t_full
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  initial begin
    repeat (4) @(posedge mclk);
    #1 rst_n = 1'b1;
    t_sel();
    t_del();
    t_fmt();
    t_tab();
    t_vt();
    t_ovf();
    t_dsel();
    t_vfm();
    t_exp();
    t_full();
    complete_run();
  end
  // The tests need well under two thousand cycles; the limit is 40000 cycles, more than twenty times that.
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
endmodule : pcp_parser_tb_top
bind pcp_parser pcp_parser_monitor mon_u (.mclk, .rst_n, .select_disable_strap,
  .mech_busy, .mech_cmd, .lb_wr, .status);
